// [rtl/fbm_pkg.sv]
// constants, types and pin carrier for the flash block manager host
package fbm_pkg;

    localparam int CLK_NS      = 32'h8;
    localparam int T_STROBE_NS = 32'h19;
    localparam int T_WB_NS     = 32'h64;
    // strobe low spans two ticks
    localparam int TICK_CYC    = (T_STROBE_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
    localparam int WB_CYC      = (T_WB_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] TICK_LAST = 3'(TICK_CYC - 1);
    localparam logic [9:0] WB_LAST   = 10'(WB_CYC - 1);

    localparam logic [9:0] SECTOR_BYTES    = 10'h210;
    localparam logic [9:0] SECTOR_LAST     = 10'h20F;
    localparam logic [9:0] LAST_BLOCK      = 10'h3FF;
    localparam logic [9:0] ADDR_LAST_RW    = 10'h003;
    localparam logic [9:0] ADDR_LAST_ERASE = 10'h001;
    localparam logic [2:0] MAX_PARTIAL     = 3'h4;

    localparam logic [7:0] CMD_READ     = 8'h00;
    localparam logic [7:0] CMD_READ_GO  = 8'h30;
    localparam logic [7:0] CMD_PROG     = 8'h80;
    localparam logic [7:0] CMD_PROG_GO  = 8'h10;
    localparam logic [7:0] CMD_ERASE    = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
    localparam logic [7:0] CMD_STATUS   = 8'h70;
    localparam logic [7:0] BAD_MARK     = 8'h00;
    localparam logic [7:0] PAD_BYTE     = 8'hFF;
    localparam int ST_FAIL_BIT    = 32'h0;
    localparam int ST_REWRITE_BIT = 32'h3;

    typedef enum logic [1:0] {
        OP_SCAN  = 2'h0,
        OP_READ  = 2'h1,
        OP_PROG  = 2'h2,
        OP_ERASE = 2'h3
    } fbm_op_t;

    typedef enum logic [12:0] {
        S_IDLE     = 13'h0001,
        S_CHECK    = 13'h0002,
        S_CMD1     = 13'h0004,
        S_ADDR     = 13'h0008,
        S_DATA_W   = 13'h0010,
        S_CMD2     = 13'h0020,
        S_WAIT_WB  = 13'h0040,
        S_WAIT_RB  = 13'h0080,
        S_STAT_CMD = 13'h0100,
        S_STAT_RD  = 13'h0200,
        S_RDMODE   = 13'h0400,
        S_DATA_R   = 13'h0800,
        S_EVAL     = 13'h1000
    } fbm_state_t;

    typedef struct packed {
        fbm_op_t    op;
        logic [9:0] block;
        logic [5:0] page;
        logic [1:0] sector;
        logic [9:0] len;
    } fbm_req_t;

    typedef struct packed {
        logic       fail;
        logic       refused;
        logic       uncorrectable;
        logic       rewrite;
        logic       relocated;
        logic [9:0] block;
    } fbm_res_t;

    typedef struct packed {
        logic       ce_n;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       re_n;
        logic       wp_n;
        logic       io_oe_n;
        logic [7:0] io_o;
    } fbm_pins_t;

    localparam fbm_pins_t PINS_RST = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                                       re_n: 1'b1, wp_n: 1'b0, io_oe_n: 1'b1,
                                       io_o: 8'h00};

endpackage

// [rtl/fbm_bbt_mem.sv]
// bad-block table, one flag per block, registered read
`timescale 1ns/10ps
module fbm_bbt_mem (
    input  wire logic       mclk,
    input  wire logic       we,
    input  wire logic [9:0] waddr,
    input  wire logic       wdata,
    input  wire logic [9:0] raddr,
    output logic            rdata
);
    logic mem [0:1023];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// [rtl/fbm_host.sv]
// host sequencer: bad-block scan, read, program, erase with block management
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module fbm_host (
    input  wire logic               mclk,
    input  wire logic               resetn,
    input  wire fbm_pkg::fbm_req_t  req,
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire logic [7:0]         wr_data,
    input  wire logic               wr_valid,
    output logic                    wr_ready,
    output logic [7:0]              rd_data,
    output logic                    rd_valid,
    output fbm_pkg::fbm_res_t       res,
    output logic                    done,
    output fbm_pkg::fbm_pins_t      pins,
    input  wire logic [7:0]         io_i,
    input  wire logic               ryby
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    function automatic logic [7:0] cmd_byte(input fbm_pkg::fbm_op_t op, input logic second);
        logic [7:0] b;
        b = second ? fbm_pkg::CMD_READ_GO : fbm_pkg::CMD_READ;
        if (op == fbm_pkg::OP_PROG) begin
            b = second ? fbm_pkg::CMD_PROG_GO : fbm_pkg::CMD_PROG;
        end else if (op == fbm_pkg::OP_ERASE) begin
            b = second ? fbm_pkg::CMD_ERASE_GO : fbm_pkg::CMD_ERASE;
        end
        return b;
    endfunction

    function automatic logic [7:0] addr_byte(input logic [1:0] idx, input logic [11:0] col,
                                             input logic [15:0] row, input logic erase);
        logic [7:0] b;
        b = row[15:8];
        if (erase) begin
            b = idx[0] ? row[15:8] : row[7:0];
        end else if (idx == 2'h0) begin
            b = col[7:0];
        end else if (idx == 2'h1) begin
            b = {4'h0, col[11:8]};
        end else if (idx == 2'h2) begin
            b = row[7:0];
        end
        return b;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // state and registers
    fbm_pkg::fbm_state_t st_r;
    fbm_pkg::fbm_state_t st_nxt;
    fbm_pkg::fbm_req_t   req_r;
    fbm_pkg::fbm_res_t   res_r;
    fbm_pkg::fbm_res_t   res_nxt;
    fbm_pkg::fbm_pins_t  pins_r;
    fbm_pkg::fbm_pins_t  pins_nxt;
    logic [9:0]          cnt_r;
    logic [9:0]          cnt_nxt;
    logic [9:0]          blk_r;
    logic [9:0]          blk_nxt;
    logic [9:0]          start_blk_r;
    logic [2:0]          tick_cnt_r;
    logic [1:0]          phase_r;
    logic [7:0]          out_byte_r;
    logic [7:0]          cap_r;
    logic [7:0]          stat_r;
    logic [7:0]          rd_data_r;
    logic                rd_valid_r;
    logic                done_r;
    logic                scanned_r;
    logic                reloc_r;
    logic [15:0]         pp_row_r;
    logic [2:0]          pp_cnt_r;
    logic                rb_m_r;
    logic                rb_s_r;
    logic [7:0]          io_m_r;
    logic [7:0]          io_s_r;
    logic                fin;
    logic                tbl_we;
    logic                tbl_wbad;
    logic                tbl_rdata;
    logic                pp_inc;
    logic                pp_clr;
    logic                reloc_set;

    //////////////////////////////////////////////////////////////////////////
    // decode
    wire fbm_pkg::fbm_op_t op = req_r.op;
    wire is_erase = (op == fbm_pkg::OP_ERASE);
    wire is_prog  = (op == fbm_pkg::OP_PROG);
    wire is_read  = (op == fbm_pkg::OP_READ);
    wire is_scan  = (op == fbm_pkg::OP_SCAN);
    wire tick     = (tick_cnt_r == fbm_pkg::TICK_LAST);
    wire cmd_st   = (st_r == fbm_pkg::S_CMD1) || (st_r == fbm_pkg::S_CMD2)
                 || (st_r == fbm_pkg::S_STAT_CMD) || (st_r == fbm_pkg::S_RDMODE);
    wire wr_st    = cmd_st || (st_r == fbm_pkg::S_ADDR) || (st_r == fbm_pkg::S_DATA_W);
    wire rd_st    = (st_r == fbm_pkg::S_STAT_RD) || (st_r == fbm_pkg::S_DATA_R);
    wire need_byte = (st_r == fbm_pkg::S_DATA_W) && (cnt_r < req_r.len);
    wire stall    = need_byte && (phase_r == 2'h0) && !wr_valid;
    wire adv      = tick && (wr_st || rd_st) && !stall;
    wire cyc_end  = adv && (phase_r == 2'h3);
    wire strobe   = (phase_r == 2'h1) || (phase_r == 2'h2);
    wire [15:0] row = {blk_r, req_r.page};
    wire [11:0] col = {10'h000, req_r.sector} * {2'h0, fbm_pkg::SECTOR_BYTES};
    wire [9:0] addr_last = is_erase ? fbm_pkg::ADDR_LAST_ERASE : fbm_pkg::ADDR_LAST_RW;
    wire pp_full  = (row == pp_row_r) && (pp_cnt_r == fbm_pkg::MAX_PARTIAL);
    wire refuse   = !scanned_r || (tbl_rdata && !is_read) || (pp_full && is_prog);
    wire stat_fail = stat_r[fbm_pkg::ST_FAIL_BIT];
    wire [7:0] data_byte = need_byte ? wr_data : fbm_pkg::PAD_BYTE;
    wire [7:0] byte_sel =
        (st_r == fbm_pkg::S_CMD1)     ? cmd_byte(op, 1'b0) :
        (st_r == fbm_pkg::S_CMD2)     ? cmd_byte(op, 1'b1) :
        (st_r == fbm_pkg::S_ADDR)     ? addr_byte(cnt_r[1:0], col, row, is_erase) :
        (st_r == fbm_pkg::S_DATA_W)   ? data_byte :
        (st_r == fbm_pkg::S_STAT_CMD) ? fbm_pkg::CMD_STATUS : fbm_pkg::CMD_READ;

    assign req_ready = (st_r == fbm_pkg::S_IDLE);
    assign wr_ready  = need_byte && (phase_r == 2'h0) && tick;
    assign rd_data   = rd_data_r;
    assign rd_valid  = rd_valid_r;
    assign res       = res_r;
    assign done      = done_r;
    assign pins      = pins_r;

    assign pins_nxt.ce_n    = (st_r == fbm_pkg::S_IDLE) || (st_r == fbm_pkg::S_CHECK);
    assign pins_nxt.cle     = cmd_st;
    assign pins_nxt.ale     = (st_r == fbm_pkg::S_ADDR);
    assign pins_nxt.we_n    = !(wr_st && strobe);
    assign pins_nxt.re_n    = !(rd_st && strobe);
    assign pins_nxt.wp_n    = 1'b1;
    assign pins_nxt.io_oe_n = !wr_st;
    assign pins_nxt.io_o    = out_byte_r;

    fbm_bbt_mem u_bbt (
        .mclk  (mclk),
        .we    (tbl_we),
        .waddr (blk_r),
        .wdata (tbl_wbad),
        .raddr (blk_r),
        .rdata (tbl_rdata)
    );

    //////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        st_nxt    = st_r;
        cnt_nxt   = cnt_r;
        blk_nxt   = blk_r;
        res_nxt   = res_r;
        fin       = 1'b0;
        tbl_we    = 1'b0;
        tbl_wbad  = 1'b0;
        pp_inc    = 1'b0;
        pp_clr    = 1'b0;
        reloc_set = 1'b0;
        unique case (st_r)
            fbm_pkg::S_IDLE: if (req_valid) begin
                st_nxt  = (req.op == fbm_pkg::OP_SCAN) ? fbm_pkg::S_CMD1 : fbm_pkg::S_CHECK;
                cnt_nxt = 10'h000;
                blk_nxt = (req.op == fbm_pkg::OP_SCAN) ? 10'h000 : req.block;
            end
            fbm_pkg::S_CHECK: if (cnt_r == 10'h001) begin
                cnt_nxt = 10'h000;
                if (reloc_r && tbl_rdata && (blk_r != start_blk_r)) begin
                    blk_nxt = blk_r + 10'h001;
                end else if (refuse) begin
                    fin     = 1'b1;
                    st_nxt  = fbm_pkg::S_IDLE;
                    res_nxt = '{fail: reloc_r, refused: 1'b1, uncorrectable: 1'b0,
                                rewrite: 1'b0, relocated: reloc_r, block: blk_r};
                end else begin
                    st_nxt = fbm_pkg::S_CMD1;
                end
            end else begin
                cnt_nxt = cnt_r + 10'h001;
            end
            fbm_pkg::S_CMD1: if (cyc_end) begin
                st_nxt  = fbm_pkg::S_ADDR;
                cnt_nxt = 10'h000;
            end
            fbm_pkg::S_ADDR: if (cyc_end) begin
                cnt_nxt = cnt_r + 10'h001;
                if (cnt_r == addr_last) begin
                    st_nxt  = is_prog ? fbm_pkg::S_DATA_W : fbm_pkg::S_CMD2;
                    cnt_nxt = 10'h000;
                end
            end
            fbm_pkg::S_DATA_W: if (cyc_end) begin
                cnt_nxt = cnt_r + 10'h001;
                if (cnt_r == fbm_pkg::SECTOR_LAST) begin
                    st_nxt  = fbm_pkg::S_CMD2;
                    cnt_nxt = 10'h000;
                end
            end
            fbm_pkg::S_CMD2: if (cyc_end) begin
                st_nxt  = fbm_pkg::S_WAIT_WB;
                cnt_nxt = 10'h000;
            end
            fbm_pkg::S_WAIT_WB: begin
                cnt_nxt = cnt_r + 10'h001;
                if (cnt_r == fbm_pkg::WB_LAST) begin
                    st_nxt = fbm_pkg::S_WAIT_RB;
                end
            end
            fbm_pkg::S_WAIT_RB: if (rb_s_r) begin
                st_nxt  = is_scan ? fbm_pkg::S_DATA_R : fbm_pkg::S_STAT_CMD;
                cnt_nxt = 10'h000;
            end
            fbm_pkg::S_STAT_CMD: if (cyc_end) begin
                st_nxt = fbm_pkg::S_STAT_RD;
            end
            fbm_pkg::S_STAT_RD: if (cyc_end) begin
                st_nxt = is_read ? fbm_pkg::S_RDMODE : fbm_pkg::S_EVAL;
            end
            fbm_pkg::S_RDMODE: if (cyc_end) begin
                st_nxt  = fbm_pkg::S_DATA_R;
                cnt_nxt = 10'h000;
            end
            fbm_pkg::S_DATA_R: if (cyc_end) begin
                cnt_nxt = cnt_r + 10'h001;
                if (cnt_r >= req_r.len - 10'h001) begin
                    st_nxt = fbm_pkg::S_EVAL;
                end
            end
            fbm_pkg::S_EVAL: begin
                fin     = 1'b1;
                st_nxt  = fbm_pkg::S_IDLE;
                res_nxt = '{fail: stat_fail && !is_scan && !is_read, refused: 1'b0,
                            uncorrectable: is_read && stat_fail,
                            rewrite: is_read && stat_r[fbm_pkg::ST_REWRITE_BIT],
                            relocated: reloc_r, block: blk_r};
                if (is_scan) begin
                    tbl_we   = 1'b1;
                    tbl_wbad = (cap_r == fbm_pkg::BAD_MARK);
                    if (blk_r != fbm_pkg::LAST_BLOCK) begin
                        fin     = 1'b0;
                        st_nxt  = fbm_pkg::S_CMD1;
                        blk_nxt = blk_r + 10'h001;
                    end
                end else if (is_erase) begin
                    tbl_we   = stat_fail;
                    tbl_wbad = 1'b1;
                    pp_clr   = !stat_fail && (blk_r == pp_row_r[15:6]);
                end else if (is_prog) begin
                    tbl_we   = stat_fail;
                    tbl_wbad = 1'b1;
                    pp_inc   = !stat_fail;
                    if (stat_fail) begin
                        fin       = 1'b0;
                        reloc_set = 1'b1;
                        st_nxt    = fbm_pkg::S_CHECK;
                        cnt_nxt   = 10'h000;
                        blk_nxt   = blk_r + 10'h001;
                    end
                end
            end
            default: st_nxt = fbm_pkg::S_IDLE;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // flops
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r  <= fbm_pkg::S_IDLE;
            cnt_r <= 10'h000;
            blk_r <= 10'h000;
            res_r <= '0;
            done_r <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
            blk_r <= blk_nxt;
            res_r <= res_nxt;
            done_r <= fin;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            req_r <= '0;
            reloc_r <= 1'b0;
            start_blk_r <= 10'h000;
            scanned_r <= 1'b0;
        end else begin
            if (req_valid && req_ready) begin
                req_r <= req;
                reloc_r <= 1'b0;
                if (req.op == fbm_pkg::OP_SCAN) begin
                    req_r.page   <= 6'h00;
                    req_r.sector <= 2'h0;
                    req_r.len    <= 10'h001;
                end
            end else if (reloc_set) begin
                reloc_r <= 1'b1;
                start_blk_r <= blk_r;
            end
            if (fin && is_scan) begin
                scanned_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pp_row_r <= 16'h0000;
            pp_cnt_r <= 3'h0;
        end else if (pp_inc) begin
            pp_row_r <= row;
            pp_cnt_r <= (row == pp_row_r) ? pp_cnt_r + 3'h1 : 3'h1;
        end else if (pp_clr) begin
            pp_cnt_r <= 3'h0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_r <= 3'h0;
            phase_r    <= 2'h0;
            out_byte_r <= 8'h00;
            pins_r     <= fbm_pkg::PINS_RST;
        end else begin
            tick_cnt_r <= tick ? 3'h0 : tick_cnt_r + 3'h1;
            phase_r    <= (wr_st || rd_st) ? phase_r + {1'b0, adv} : 2'h0;
            if (adv && (phase_r == 2'h0)) begin
                out_byte_r <= byte_sel;
            end
            pins_r <= pins_nxt;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rb_m_r <= 1'b0;
            rb_s_r <= 1'b0;
            io_m_r <= 8'h00;
            io_s_r <= 8'h00;
            cap_r  <= 8'h00;
            stat_r <= 8'h00;
            rd_data_r  <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rb_m_r <= ryby;
            rb_s_r <= rb_m_r;
            io_m_r <= io_i;
            io_s_r <= io_m_r;
            if (adv && rd_st && (phase_r == 2'h2)) begin
                cap_r <= io_s_r;
            end
            if (cyc_end && (st_r == fbm_pkg::S_STAT_RD)) begin
                stat_r <= cap_r;
            end
            rd_valid_r <= cyc_end && (st_r == fbm_pkg::S_DATA_R) && is_read;
            if (cyc_end && (st_r == fbm_pkg::S_DATA_R)) begin
                rd_data_r <= cap_r;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    a_addr_four: assert property ((st_r == fbm_pkg::S_ADDR) |-> (cnt_r <= fbm_pkg::ADDR_LAST_RW))
        else $error("more than four address cycles");
    a_sector_whole: assert property ((st_r == fbm_pkg::S_DATA_W && st_nxt == fbm_pkg::S_CMD2)
        |-> (cnt_r == fbm_pkg::SECTOR_LAST)) else $error("program sector not whole");
    a_main_spare: assert property ((st_r == fbm_pkg::S_CMD2 && is_prog)
        |-> $past(st_r) inside {fbm_pkg::S_DATA_W, fbm_pkg::S_CMD2}) else $error("split sector");
    a_partial_cap: assert property ((st_r == fbm_pkg::S_CHECK && cnt_r == 10'h001 && is_prog
        && pp_full && !reloc_r) |=> (st_r == fbm_pkg::S_IDLE) && res_r.refused)
        else $error("fifth partial program allowed");
    a_erase_good: assert property ((st_r == fbm_pkg::S_CMD1 && is_erase) |-> !tbl_rdata)
        else $error("erase issued to bad block");
    a_scan_first: assert property ((st_r == fbm_pkg::S_CMD1 && !is_scan) |-> scanned_r)
        else $error("access before scan");
    a_bad_mark: assert property ((st_r == fbm_pkg::S_EVAL && is_scan)
        |-> tbl_we && (tbl_wbad == (cap_r == fbm_pkg::BAD_MARK))) else $error("scan mark wrong");
    a_scan_nostat: assert property (is_scan |-> (st_r != fbm_pkg::S_STAT_CMD))
        else $error("status read during scan");
    a_erase_fail: assert property ((st_r == fbm_pkg::S_EVAL && is_erase && stat_fail)
        |-> (tbl_we && tbl_wbad) ##1 (done_r && res_r.fail)) else $error("erase fail not marked");
    a_prog_reloc: assert property ((st_r == fbm_pkg::S_EVAL && is_prog && stat_fail)
        |=> (st_r == fbm_pkg::S_CHECK) && (blk_r != $past(blk_r))) else $error("no relocation");
    a_rewrite_flag: assert property ((st_r == fbm_pkg::S_EVAL && is_read)
        |=> done_r && (res_r.rewrite == $past(stat_r[3]))) else $error("rewrite flag lost");
    a_read_nomark: assert property (is_read |-> !tbl_we)
        else $error("read marked a block");
    a_pad_ones: assert property ((st_r == fbm_pkg::S_DATA_W && phase_r == 2'h1
        && cnt_r >= req_r.len) |-> (out_byte_r == fbm_pkg::PAD_BYTE)) else $error("pad not ones");
    a_status_bit: assert property ((st_r == fbm_pkg::S_EVAL && is_erase)
        |=> (res_r.fail == $past(stat_r[0]))) else $error("pass fail bit misread");
    a_table_check: assert property ((st_r == fbm_pkg::S_CMD1 && is_prog) |-> !tbl_rdata)
        else $error("program to bad block");
endmodule

// [test/fbm_flash_model.sv]
// behavioural flash device facing the host pins
`timescale 1ns/10ps
module fbm_flash_model #(
    parameter logic [9:0] BAD_A = 10'h005,
    parameter logic [9:0] BAD_B = 10'h3FF
) (
    input  wire fbm_pkg::fbm_pins_t pins,
    input  wire logic [9:0]         fail_blk,
    input  wire logic [7:0]         rd_stat,
    output logic [7:0]              io_i,
    output logic                    ryby
);
    logic [7:0]  mem [int];
    logic [7:0]  cmd = 8'h00;
    logic [7:0]  st = 8'h00;
    logic [7:0]  dout = 8'h00;
    logic [15:0] row = 16'h0000;
    logic [15:0] col = 16'h0000;
    int          acnt = 0;
    int          pcnt = 0;
    initial ryby = 1'b1;
    // released bus shows the inverse of the last byte
    assign io_i = (!pins.ce_n && !pins.re_n) ? dout : ~dout;
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.cle) begin
            cmd = pins.io_o;
            acnt = (cmd == 8'h60) ? 2 : 0;
            if (cmd == 8'h80) pcnt = 0;
            if (cmd == 8'h30 || cmd == 8'h10 || cmd == 8'hD0) begin
                st = (cmd == 8'h30) ? rd_stat : {7'h30, (row[15:6] == fail_blk)
                     || (cmd == 8'h10 && pcnt != 528)};
                ryby <= 1'b0;
                ryby <= #100 1'b1;
            end
        end else if (!pins.ce_n && pins.ale) begin
            if (acnt < 2) col[8*acnt +: 8] = pins.io_o;
            else if (acnt < 4) row[8*acnt-16 +: 8] = pins.io_o;
            acnt = acnt + 1;
        end else if (!pins.ce_n && cmd == 8'h80) begin
            mem[{row, col}] = pins.io_o;
            col = col + 16'h0001;
            pcnt = pcnt + 1;
        end
    end
    always @(negedge pins.re_n) begin
        if (cmd == 8'h70) dout = st;
        else begin
            dout = ((row[15:6] == BAD_A || row[15:6] == BAD_B) && col == 16'h0000) ? 8'h00 :
                   (mem.exists({row, col}) ? mem[{row, col}] : 8'hFF);
            col = col + 16'h0001;
        end
    end
endmodule

// [test/testbench.sv]
// self-checking bench for the flash block manager host
`timescale 1ns/10ps
module testbench;
    logic               mclk, resetn, req_valid, req_ready, wr_valid, wr_ready;
    logic               rd_valid, done, ryby;
    logic [7:0]         wr_data, rd_data, io_i;
    logic [7:0]         rd_stat = 8'h61;
    logic [9:0]         fail_blk = 10'h3FE;
    fbm_pkg::fbm_req_t  req;
    fbm_pkg::fbm_res_t  res, r;
    fbm_pkg::fbm_pins_t pins;
    logic [7:0]         rq [$];
    int                 errors = 0, cmp_count = 0, cyc = 0, idx = 0;

    fbm_host dut (.mclk(mclk), .resetn(resetn), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .res(res), .done(done), .pins(pins),
        .io_i(io_i), .ryby(ryby));
    fbm_flash_model flash (.pins(pins), .fail_blk(fail_blk), .rd_stat(rd_stat),
        .io_i(io_i), .ryby(ryby));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (wr_valid && wr_ready) idx <= idx + 1;
        if (cyc == 120000) begin
            errors++;
            final_report();
        end
    end
    always @(negedge mclk) begin
        wr_data <= 8'hA0 + 8'(idx);
        if (rd_valid === 1'b1) rq.push_back(rd_data);
    end
    //////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic c, input string m);
        cmp_count++;
        if (c !== 1'b1) begin
            errors++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask
    task automatic op(input fbm_pkg::fbm_op_t o, input logic [9:0] b, input logic [1:0] s,
                      input logic [9:0] n);
        int i;
        @(negedge mclk);
        req = '{op: o, block: b, page: 6'h00, sector: s, len: n};
        req_valid = 1'b1;
        idx = 0;
        rq.delete();
        @(negedge mclk);
        req_valid = 1'b0;
        for (i = 0; i < 300000 && done !== 1'b1; i++) @(negedge mclk);
        r = res;
    endtask
    //////////////////////////////////////////////////////////////////////////////
    task automatic t_before_scan();
        op(fbm_pkg::OP_ERASE, 10'h002, 2'h0, 10'h000);
        chk(r.refused === 1'b1, "erase before scan accepted");
    endtask
    task automatic t_scan();
        op(fbm_pkg::OP_SCAN, 10'h000, 2'h0, 10'h000);
        chk(r.refused === 1'b0, "scan refused");
        rd_stat = 8'h60;
        op(fbm_pkg::OP_ERASE, 10'h005, 2'h0, 10'h000);
        chk(r.refused === 1'b1, "bad block erased");
        op(fbm_pkg::OP_ERASE, 10'h3FF, 2'h0, 10'h000);
        chk(r.refused === 1'b1, "last bad block erased");
    endtask
    task automatic t_partial();
        for (int k = 0; k < 4; k++) begin
            op(fbm_pkg::OP_PROG, 10'h002, 2'(k), 10'h003);
            chk(r.refused === 1'b0 && r.fail === 1'b0, "partial program refused");
        end
        op(fbm_pkg::OP_PROG, 10'h002, 2'h0, 10'h003);
        chk(r.refused === 1'b1, "fifth partial program accepted");
        op(fbm_pkg::OP_READ, 10'h002, 2'h1, 10'h004);
        chk(rq.size() == 4, "read length");
        if (rq.size() == 4)
            chk(rq[0] === 8'hA0 && rq[2] === 8'hA2 && rq[3] === 8'hFF, "sector data");
    endtask
    task automatic t_prog_fail();
        fail_blk = 10'h007;
        op(fbm_pkg::OP_PROG, 10'h007, 2'h0, 10'h002);
        chk(r.relocated === 1'b1 && r.block === 10'h008, "no relocation");
        op(fbm_pkg::OP_ERASE, 10'h007, 2'h0, 10'h000);
        chk(r.refused === 1'b1, "failed block erased");
    endtask
    task automatic t_erase_fail();
        fail_blk = 10'h009;
        op(fbm_pkg::OP_ERASE, 10'h009, 2'h0, 10'h000);
        chk(r.fail === 1'b1, "erase fail missed");
        op(fbm_pkg::OP_ERASE, 10'h009, 2'h0, 10'h000);
        chk(r.refused === 1'b1, "failed erase block reused");
    endtask
    task automatic t_read_status();
        rd_stat = 8'h68;
        op(fbm_pkg::OP_READ, 10'h003, 2'h0, 10'h001);
        chk(r.rewrite === 1'b1 && r.uncorrectable === 1'b0, "rewrite advice");
        rd_stat = 8'h61;
        op(fbm_pkg::OP_READ, 10'h003, 2'h0, 10'h001);
        chk(r.uncorrectable === 1'b1, "uncorrectable missed");
        op(fbm_pkg::OP_ERASE, 10'h003, 2'h0, 10'h000);
        chk(r.refused === 1'b0 && r.fail === 1'b0, "read error marked block");
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        req = '0;
        req_valid = 1'b0;
        wr_valid = 1'b1;
        wr_data = 8'h00;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        resetn = 1'b1;
        t_before_scan();
        t_scan();
        t_partial();
        t_prog_fail();
        t_erase_fail();
        t_read_status();
        final_report();
    end
endmodule
